// [verilog/dcsf_map.vh]
// Constants for the dual-channel one-bit serial FIFO
`ifndef DCSF_MAP_VH
`define DCSF_MAP_VH

// Address widths for the two depth options
`define DCSF_AW_SMALL 6
`define DCSF_AW_LARGE 8

// Channel count
`define DCSF_CHANNELS 2

// Distance from empty or full at which the boundary flag is set
`define DCSF_ALMOST_GAP 4'h8

// Flag values while a channel is cleared
`define DCSF_HF_CLR 1'b0
`define DCSF_AE_CLR 1'b1
`define DCSF_VALID_CLR 1'b0
`define DCSF_ARM_CLR 1'b0

// Values taken once a channel runs
`define DCSF_ARM_SET 1'b1
`define DCSF_VALID_SET 1'b1

// Channel clock samples after reset, as if the clocks were low
`define DCSF_EDGE_CLR 1'b0

`endif

// [verilog/dcsf_mem.v]
// One-bit storage array with registered read data
`timescale 1ns/1ps
`default_nettype none

module dcsf_mem #(
    parameter AW = 6
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire i_wr_en,
    input wire [AW-1:0] i_wr_addr,
    input wire i_wr_data,
    input wire i_rd_en,
    input wire [AW-1:0] i_rd_addr,
    output reg o_rd_data
);

    reg store_reg [0:(1<<AW)-1];

    // ==========================================================
    // Write port
    always @(posedge i_clk) begin
        if (i_ce && i_wr_en) begin
            store_reg[i_wr_addr] <= i_wr_data;
        end
    end

    // ==========================================================
    // Read port, output held between fetches
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 1'b0;
        end else if (i_ce && i_rd_en) begin
            o_rd_data <= store_reg[i_rd_addr];
        end
    end

endmodule

`default_nettype wire

// [verilog/dcsf_top.v]
// Dual-channel one-bit first-in first-out buffer
`timescale 1ns/1ps
`default_nettype none
`include "dcsf_map.vh"

module dcsf_top #(
    parameter LARGE = 0
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire [`DCSF_CHANNELS-1:0] i_write_clock,
    input wire [`DCSF_CHANNELS-1:0] i_write_enable,
    input wire [`DCSF_CHANNELS-1:0] i_write_data,
    input wire [`DCSF_CHANNELS-1:0] i_read_clock,
    input wire [`DCSF_CHANNELS-1:0] i_read_enable,
    input wire [`DCSF_CHANNELS-1:0] i_output_drive_enable,
    input wire [`DCSF_CHANNELS-1:0] i_channel_reset_n,
    output wire [`DCSF_CHANNELS-1:0] o_write_space_flag,
    output wire [`DCSF_CHANNELS-1:0] o_read_valid_flag,
    output wire [`DCSF_CHANNELS-1:0] o_half_full_flag,
    output wire [`DCSF_CHANNELS-1:0] o_almost_boundary_flag,
    output wire [`DCSF_CHANNELS-1:0] o_read_data,
    output wire [`DCSF_CHANNELS-1:0] o_read_data_oe
);

    // ==========================================================
    // Depth selection
    localparam AW = (LARGE != 0) ? `DCSF_AW_LARGE : `DCSF_AW_SMALL;
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
    localparam [AW:0] HALF = {2'b01, {(AW-1){1'b0}}};
    localparam [AW:0] GAP = {{(AW-3){1'b0}}, `DCSF_ALMOST_GAP};
    localparam [AW:0] NEAR_FULL = DEPTH - GAP;
    localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};
    localparam [AW:0] ZERO = {(AW+1){1'b0}};

    // ==========================================================
    // Pointer code conversion
    function [AW:0] bin2gray;
        input [AW:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    function [AW:0] gray2bin;
        input [AW:0] g;
        integer k;
        begin
            gray2bin[AW] = g[AW];
            for (k = AW - 1; k >= 0; k = k - 1) begin
                gray2bin[k] = gray2bin[k + 1] ^ g[k];
            end
        end
    endfunction

    // Rise of a sampled channel clock
    function rise_seen;
        input now_level;
        input last_level;
        begin
            rise_seen = now_level & ~last_level;
        end
    endfunction

    // Pointer advance; the extra top bit tells full from empty
    function [AW:0] step_ptr;
        input [AW:0] p;
        input go;
        begin
            step_ptr = go ? (p + ONE) : p;
        end
    endfunction

    // ==========================================================
    // Level decodes
    function count_full;
        input [AW:0] n;
        begin
            count_full = (n == DEPTH);
        end
    endfunction

    function count_half;
        input [AW:0] n;
        begin
            count_half = (n >= HALF);
        end
    endfunction

    function count_boundary;
        input [AW:0] n;
        begin
            count_boundary = (n <= GAP) | (n >= NEAR_FULL);
        end
    endfunction

    // ==========================================================
    // One instance of the channel logic per channel
    genvar ch;
    generate
        for (ch = 0; ch < `DCSF_CHANNELS; ch = ch + 1) begin : g_chan

            reg wclk_prev_reg;
            reg rclk_prev_reg;
            wire chan_clr;
            wire wr_tick;
            wire rd_tick;

            // Write-side state
            reg [AW:0] wptr_reg;
            reg [AW:0] wgray_reg;
            reg [AW:0] rsync1_reg;
            reg [AW:0] rsync2_reg;
            reg arm1_reg;
            reg arm2_reg;
            reg hf_reg;
            reg ae_reg;
            wire [AW:0] rptr_seen;
            wire [AW:0] level;
            wire full;
            wire space;
            wire push;
            wire [AW:0] wptr_next;

            // Read-side state
            reg [AW:0] rptr_reg;
            reg [AW:0] rgray_reg;
            reg [AW:0] wsync1_reg;
            reg [AW:0] wsync2_reg;
            reg valid_reg;
            wire [AW:0] wptr_seen;
            wire has_data;
            wire pop;
            wire fetch;
            wire [AW:0] rptr_next;

            // ==================================================
            // Channel clocks arrive as sampled levels; act on rises
            assign chan_clr = ~i_channel_reset_n[ch];
            assign wr_tick = i_ce & rise_seen(i_write_clock[ch], wclk_prev_reg);
            assign rd_tick = i_ce & rise_seen(i_read_clock[ch], rclk_prev_reg);

            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    wclk_prev_reg <= `DCSF_EDGE_CLR;
                end else if (i_ce) begin
                    wclk_prev_reg <= i_write_clock[ch];
                end
            end

            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    rclk_prev_reg <= `DCSF_EDGE_CLR;
                end else if (i_ce) begin
                    rclk_prev_reg <= i_read_clock[ch];
                end
            end

            // ==================================================
            // Write side
            assign rptr_seen = gray2bin(rsync2_reg);
            assign level = wptr_reg - rptr_seen;
            assign full = count_full(level);
            assign space = arm2_reg & ~full;
            assign push = wr_tick & i_write_enable[ch] & space;
            assign wptr_next = step_ptr(wptr_reg, push);

            // Write pointer with its gray copy for the read side
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    wptr_reg <= ZERO;
                    wgray_reg <= ZERO;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        wptr_reg <= ZERO;
                        wgray_reg <= ZERO;
                    end else if (wr_tick) begin
                        wptr_reg <= wptr_next;
                        wgray_reg <= bin2gray(wptr_next);
                    end
                end
            end

            // Read pointer into the write domain; only gray code crosses
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    rsync1_reg <= ZERO;
                    rsync2_reg <= ZERO;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        rsync1_reg <= ZERO;
                        rsync2_reg <= ZERO;
                    end else if (wr_tick) begin
                        rsync1_reg <= rgray_reg;
                        rsync2_reg <= rsync1_reg;
                    end
                end
            end

            // Space flag held off for two write ticks after a clear
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    arm1_reg <= `DCSF_ARM_CLR;
                    arm2_reg <= `DCSF_ARM_CLR;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        arm1_reg <= `DCSF_ARM_CLR;
                        arm2_reg <= `DCSF_ARM_CLR;
                    end else if (wr_tick) begin
                        arm1_reg <= `DCSF_ARM_SET;
                        arm2_reg <= arm1_reg;
                    end
                end
            end

            // Half-full flag from the write-side count
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    hf_reg <= `DCSF_HF_CLR;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        hf_reg <= `DCSF_HF_CLR;
                    end else begin
                        hf_reg <= count_half(level);
                    end
                end
            end

            // Boundary flag, near empty or near full
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    ae_reg <= `DCSF_AE_CLR;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        ae_reg <= `DCSF_AE_CLR;
                    end else begin
                        ae_reg <= count_boundary(level);
                    end
                end
            end

            // ==================================================
            // Read side
            assign wptr_seen = gray2bin(wsync2_reg);
            assign has_data = (wptr_seen != rptr_reg);
            assign pop = rd_tick & i_read_enable[ch] & valid_reg;
            assign fetch = rd_tick & has_data & (~valid_reg | pop);
            assign rptr_next = step_ptr(rptr_reg, fetch);

            // Read pointer with its gray copy for the write side
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    rptr_reg <= ZERO;
                    rgray_reg <= ZERO;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        rptr_reg <= ZERO;
                        rgray_reg <= ZERO;
                    end else if (rd_tick) begin
                        rptr_reg <= rptr_next;
                        rgray_reg <= bin2gray(rptr_next);
                    end
                end
            end

            // Write pointer into the read domain; valid is the third stage
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    wsync1_reg <= ZERO;
                    wsync2_reg <= ZERO;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        wsync1_reg <= ZERO;
                        wsync2_reg <= ZERO;
                    end else if (rd_tick) begin
                        wsync1_reg <= wgray_reg;
                        wsync2_reg <= wsync1_reg;
                    end
                end
            end

            // Output-ready flag
            always @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    valid_reg <= `DCSF_VALID_CLR;
                end else if (i_ce) begin
                    if (chan_clr) begin
                        valid_reg <= `DCSF_VALID_CLR;
                    end else if (rd_tick) begin
                        if (fetch) begin
                            valid_reg <= `DCSF_VALID_SET;
                        end else if (pop) begin
                            valid_reg <= `DCSF_VALID_CLR;
                        end
                    end
                end
            end

            // ==================================================
            // Storage and output bit
            dcsf_mem #(
                .AW(AW)
            ) u_mem (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_ce(i_ce),
                .i_wr_en(push),
                .i_wr_addr(wptr_reg[AW-1:0]),
                .i_wr_data(i_write_data[ch]),
                .i_rd_en(fetch),
                .i_rd_addr(rptr_reg[AW-1:0]),
                .o_rd_data(o_read_data[ch])
            );

            assign o_read_data_oe[ch] = i_output_drive_enable[ch];
            assign o_write_space_flag[ch] = space;
            assign o_read_valid_flag[ch] = valid_reg;
            assign o_half_full_flag[ch] = hf_reg;
            assign o_almost_boundary_flag[ch] = ae_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// [testbench/dcsf_partner.sv]
// Free-running write and read clock source for one channel
`timescale 1ns/1ps
`default_nettype none
module dcsf_partner #(
    parameter int WH = 3,
    parameter int RH = 3
) (
    input wire logic i_clk,
    output logic o_write_clock = 1'b0,
    output logic o_read_clock = 1'b0
);
    int wc = 0;
    int rc = 0;
    // Never gated or stopped
    always @(posedge i_clk) begin
        wc <= (wc == WH - 1) ? 0 : wc + 1;
        rc <= (rc == RH - 1) ? 0 : rc + 1;
        if (wc == WH - 1) begin
            o_write_clock <= ~o_write_clock;
        end
        if (rc == RH - 1) begin
            o_read_clock <= ~o_read_clock;
        end
    end
endmodule
`default_nettype wire

// [testbench/dcsf_asserts.sv]
// Concurrent checks on channel 0 of the serial FIFO, and on the drive enables of both channels
`timescale 1ns/1ps
`default_nettype none
module dcsf_asserts #(
    parameter LARGE = 0
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire [1:0] i_write_clock,
    input wire [1:0] i_write_enable,
    input wire [1:0] i_write_data,
    input wire [1:0] i_read_clock,
    input wire [1:0] i_read_enable,
    input wire [1:0] i_output_drive_enable,
    input wire [1:0] i_channel_reset_n,
    input wire [1:0] o_write_space_flag,
    input wire [1:0] o_read_valid_flag,
    input wire [1:0] o_half_full_flag,
    input wire [1:0] o_almost_boundary_flag,
    input wire [1:0] o_read_data,
    input wire [1:0] o_read_data_oe
);
    wire r = i_channel_reset_n[0];
    wire sp = o_write_space_flag[0];
    wire v = o_read_valid_flag[0];
    wire hf = o_half_full_flag[0];
    wire ab = o_almost_boundary_flag[0];
    wire re = i_read_enable[0];
    wire q = o_read_data[0];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    chk_oe_follow: assert property (o_read_data_oe == i_output_drive_enable)
        else $error("drive enable not followed");
    chk_reset_clear: assert property (!r [*2] |-> !sp && !v && !hf && ab)
        else $error("flags not cleared in reset");
    chk_space_release: assert property ($rose(r) |-> !sp [*2])
        else $error("space flag early after reset");
    chk_valid_lag: assert property ($rose(r) |-> !v [*8])
        else $error("valid flag early after reset");
    chk_hold_output: assert property (v && !re && r ##1 !re && r |-> v && $stable(q))
        else $error("output bit lost without a read");
    chk_valid_drop: assert property ($fell(v) |-> $past(re) || $past(re, 2) || !$past(r))
        else $error("valid fell without a read");
    chk_half_mid: assert property ($changed(hf) && $past(r) |-> !ab)
        else $error("half flag moved at boundary level");
    chk_full_flags: assert property ($fell(sp) && r && $past(r) |=> hf && ab)
        else $error("level flags wrong at full");
    cover property ($rose(v));
    cover property ($fell(sp) && r);
    cover property ($rose(hf));
endmodule
bind dcsf_top dcsf_asserts #(.LARGE(LARGE)) u_chk (.*);
`default_nettype wire

// [testbench/dcsf_top_tb.sv]
// Self-checking bench for the dual-channel serial FIFO
`timescale 1ns/1ps
`default_nettype none
module dcsf_top_tb;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic ce = 1'b1;
    logic [1:0] we = 2'h0, wd = 2'h0, re = 2'h0, oe = 2'h3, rst_n = 2'h3;
    wire [1:0] wc, rc, sp, v, hf, ab, q, qe;
    wire [7:0] mon = {v, sp, rc, wc};
    int fail_count = 0;
    int n_checks = 0;
    int nr[7] = '{1, 9, 10, 32, 33, 57, 70};
    logic [3:0] fx[7] = '{4'hd, 4'hd, 4'hc, 4'hc, 4'he, 4'hf, 4'h7};
    dcsf_top #(.LARGE(0)) dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_write_clock(wc), .i_write_enable(we), .i_write_data(wd), .i_read_clock(rc),
        .i_read_enable(re), .i_output_drive_enable(oe), .i_channel_reset_n(rst_n),
        .o_write_space_flag(sp), .o_read_valid_flag(v), .o_half_full_flag(hf),
        .o_almost_boundary_flag(ab), .o_read_data(q), .o_read_data_oe(qe));
    dcsf_partner #(.WH(3), .RH(4)) u_p0 (.i_clk(i_clk), .o_write_clock(wc[0]),
        .o_read_clock(rc[0]));
    dcsf_partner #(.WH(3), .RH(3)) u_p1 (.i_clk(i_clk), .o_write_clock(wc[1]),
        .o_read_clock(rc[1]));
    initial forever #4 i_clk = ~i_clk;
    function automatic logic pat(int i);
        return i[0] ^ i[3] ^ (i % 3 == 0);
    endfunction
    function automatic logic [3:0] fl(int c);
        return {sp[c], v[c], hf[c], ab[c]};
    endfunction
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wt(int s, logic l);
        int k;
        k = 0;
        while (mon[s] !== l) begin
            idle(1);
            k++;
            if (k > 300) begin
                fail_count++;
                close_out();
            end
        end
    endtask
    task automatic wr(int c, int n);
        for (int i = 0; i < n; i++) begin
            wt(c, 1'b0);
            we[c] = 1'b1;
            wd[c] = pat(i);
            wt(c, 1'b1);
            wt(c, 1'b0);
        end
        we[c] = 1'b0;
    endtask
    task automatic rd(int c, int n);
        for (int i = 0; i < n; i++) begin
            wt(6 + c, 1'b1);
            wt(2 + c, 1'b0);
            idle(1);
            chk("rdata", {3'h0, pat(i)}, {3'h0, q[c]});
            re[c] = 1'b1;
            wt(2 + c, 1'b1);
            wt(2 + c, 1'b0);
            re[c] = 1'b0;
        end
    endtask
    task automatic crst(int c);
        int k, n;
        logic p;
        rst_n[c] = 1'b0;
        idle(40);
        chk("rst_flags", 4'h1, fl(c));
        wt(c, 1'b1);
        wt(c, 1'b0);
        rst_n[c] = 1'b1;
        k = 0;
        n = 0;
        p = wc[c];
        while (sp[c] !== 1'b1 && k < 60) begin
            idle(1);
            k++;
            n += (wc[c] && !p);
            p = wc[c];
        end
        chk("space_ticks", 4'h2, n[3:0]);
    endtask
    initial begin
        idle(16);
        chk("por_flags", 4'h1, fl(0));
        i_reset = 1'b0;
        crst(1);
        for (int r = 0; r < 7; r++) begin
            crst(0);
            wr(0, nr[r]);
            idle(40);
            chk("level_flags", fx[r], fl(0));
            rd(0, nr[r] > 65 ? 65 : nr[r]);
            idle(40);
            chk("empty_flags", 4'h9, fl(0));
        end
        re[1] = 1'b1;
        idle(30);
        re[1] = 1'b0;
        wr(1, 5);
        crst(0);
        idle(40);
        chk("ch1_kept", 4'hd, fl(1));
        ce = 1'b0;
        we[1] = 1'b1;
        idle(20);
        chk("ce_frozen", 4'hd, fl(1));
        chk("ce_qbit", {3'h0, pat(0)}, {3'h0, q[1]});
        we[1] = 1'b0;
        ce = 1'b1;
        rd(1, 5);
        idle(40);
        chk("ch1_empty", 4'h9, fl(1));
        oe = 2'h1;
        idle(1);
        chk("oe_pins", 4'h1, {2'h0, qe});
        close_out();
    end
endmodule
`default_nettype wire
